// ---- src/fdc_pkg.sv ----
// Constants and types shared by the floppy drive control block.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
package fdc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DRIVE_CTL = 8'h00;
  localparam logic [7:0] OFS_FUNC_EN = 8'h04;
  localparam logic [7:0] OFS_RATE_CFG = 8'h08;
  localparam logic [7:0] OFS_RATE_SEL = 8'h0C;
  localparam logic [7:0] OFS_IN_STATUS = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_SEEK = 8'h18;
  localparam logic [7:0] OFS_XFER = 8'h1C;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  // Field positions
  localparam int DOR_DRIVE_LO = 0;
  localparam int DOR_DMA_GATE = 3;
  localparam int DOR_MOTOR_LO = 4;
  localparam int FER_FOUR_DRIVE = 4;
  localparam int RATE_LO = 0;
  localparam int MODE_DIAG = 3;
  localparam int SEEK_ACTIVE = 0;
  localparam int SEEK_INWARD = 1;
  localparam int SEEK_RW = 2;
  localparam int XFER_REQ = 8;
  localparam int XFER_ACK = 9;
  localparam int XFER_SEEN = 10;
  localparam int STAT_DIAG = 0;
  localparam int STAT_DISK = 7;

  // Reset values
  localparam logic [7:0] DOR_RESET = 8'h00;
  localparam logic [7:0] FER_RESET = 8'h00;
  localparam logic [1:0] RATE_RESET = 2'h0;

  // System modes, one-hot
  typedef enum logic [2:0] {
    MODE_AT = 3'b001,
    MODE_DESK = 3'b010,
    MODE_ALT = 3'b100
  } fdc_mode_t;

  // Drive output control fields
  typedef struct packed {
    logic [3:0] motor;
    logic dmaGate;
    logic ctlEnable;
    logic [1:0] drive;
  } fdc_dor_t;

  // Seek and transfer state from software
  typedef struct packed {
    logic rwActive;
    logic inward;
    logic seekActive;
  } fdc_seek_t;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } fdc_aphase_t;
endpackage

// ---- src/fdc_sync2.sv ----
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input changes slowly compared to the clock.
`timescale 1ns/1ps
module fdc_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ---- src/fdc_drive_ctl.sv ----
// Floppy drive pin control: step direction, drive selects, rate code,
// disk-change readback and the DMA request/acknowledge handshake.
// Assumes a single AHB-Lite master and raw pins from drive and DMA side.
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module fdc_drive_ctl #(
  parameter int COUNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic disk_changed_in,
  input wire logic floppy_dma_ack_n,
  output logic stepDirection,
  output logic drive_select0_n,
  output logic drive_select1_n,
  output logic rate_code_out0,
  output logic rate_code_out1,
  output logic read_gate_diag,
  output logic floppy_dma_req,
  output logic dmaStrobeEnable
);
  // Count bits must stay below the request flag in the transfer word
  if (COUNT_W < 1 || COUNT_W > fdc_pkg::XFER_REQ) begin : g_bad_count
    $error("COUNT_W out of range");
  end

  fdc_pkg::fdc_aphase_t aph_q;
  fdc_pkg::fdc_dor_t dor_q;
  fdc_pkg::fdc_seek_t seek_q;
  fdc_pkg::fdc_mode_t mode_q;
  logic [7:0] fer_q;
  logic [1:0] rateCfg_q;
  logic [1:0] rateSel_q;
  logic [1:0] rate_q;
  logic diagSel_q;
  logic [COUNT_W-1:0] count_q;
  logic ackSeen_q;
  logic ackPrev_q;
  logic [31:0] rdata_q;
  logic diskSync;
  logic ackSync;
  logic dmaEnable;
  logic ackActive;
  logic ackEdge;
  logic wrEn;
  logic [7:0] wrOfs;
  logic [31:0] rdMux;
  logic [1:0] selN_d;
  logic stepDir_d;

  // Pins from outside pass two flops first
  fdc_sync2 #(.RESET_VAL(1'b0)) u_disk_sync (
    .clk(clk),
    .rst(rst),
    .din(disk_changed_in),
    .dout(diskSync)
  );

  // Acknowledge idles high
  fdc_sync2 #(.RESET_VAL(1'b1)) u_ack_sync (
    .clk(clk),
    .rst(rst),
    .din(floppy_dma_ack_n),
    .dout(ackSync)
  );

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Capture address phase; hsize is not checked, only words are used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aph_q <= '0;
    end else if (hready) begin
      aph_q.valid <= hsel & htrans[1];
      aph_q.write <= hwrite;
      aph_q.addr <= {haddr[fdc_pkg::ADDR_MSB:fdc_pkg::ADDR_LSB], 2'b00};
    end
  end

  assign wrEn = aph_q.valid & aph_q.write;
  assign wrOfs = aph_q.addr;

  // Drive output control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dor_q <= fdc_pkg::DOR_RESET;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_DRIVE_CTL) begin
      dor_q <= hwdata[7:0];
    end
  end

  // Function enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fer_q <= fdc_pkg::FER_RESET;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_FUNC_EN) begin
      fer_q <= hwdata[7:0];
    end
  end

  // Both rate registers; the latest write steers the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rateCfg_q <= fdc_pkg::RATE_RESET;
      rateSel_q <= fdc_pkg::RATE_RESET;
      rate_q <= fdc_pkg::RATE_RESET;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_RATE_CFG) begin
      rateCfg_q <= hwdata[fdc_pkg::RATE_LO +: 2];
      rate_q <= hwdata[fdc_pkg::RATE_LO +: 2];
    end else if (wrEn && wrOfs == fdc_pkg::OFS_RATE_SEL) begin
      rateSel_q <= hwdata[fdc_pkg::RATE_LO +: 2];
      rate_q <= hwdata[fdc_pkg::RATE_LO +: 2];
    end
  end

  // Mode register; codes that are not one-hot are ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= fdc_pkg::MODE_AT;
      diagSel_q <= 1'b0;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_MODE) begin
      diagSel_q <= hwdata[fdc_pkg::MODE_DIAG];
      unique case (hwdata[2:0])
        fdc_pkg::MODE_AT: mode_q <= fdc_pkg::MODE_AT;
        fdc_pkg::MODE_DESK: mode_q <= fdc_pkg::MODE_DESK;
        fdc_pkg::MODE_ALT: mode_q <= fdc_pkg::MODE_ALT;
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Seek state written by the sequencer software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seek_q <= '0;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_SEEK) begin
      seek_q <= hwdata[2:0];
    end
  end

  // DMA gating by mode
  always_comb begin
    unique case (mode_q)
      fdc_pkg::MODE_AT: dmaEnable = dor_q.dmaGate;
      fdc_pkg::MODE_DESK: dmaEnable = dor_q.dmaGate;
      fdc_pkg::MODE_ALT: dmaEnable = 1'b1;
      default: dmaEnable = 1'b0;
    endcase
  end

  // Ack ignored while disabled, so stray lows during PIO are harmless
  assign ackActive = dmaEnable & ~ackSync;
  assign ackEdge = ackActive & ackPrev_q;

  // Holds the inverted ack level; resets to idle so an ack held low through reset still gives an edge once synchronised
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackPrev_q <= 1'b1;
    end else begin
      ackPrev_q <= ~ackActive;
    end
  end

  // Remaining transfers; a software load wins over a decrement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_XFER) begin
      count_q <= hwdata[COUNT_W-1:0];
    end else if (ackEdge && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Sticky ack flag; a new ack beats the write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackSeen_q <= 1'b0;
    end else if (ackEdge) begin
      ackSeen_q <= 1'b1;
    end else if (wrEn && wrOfs == fdc_pkg::OFS_XFER && hwdata[fdc_pkg::XFER_SEEN]) begin
      ackSeen_q <= 1'b0;
    end
  end

  // Head direction only while seeking
  assign stepDir_d = seek_q.seekActive & seek_q.inward & ~seek_q.rwActive;

  // Drive select decode or encode, active low
  always_comb begin
    selN_d = 2'b11;
    if (fer_q[fdc_pkg::FER_FOUR_DRIVE]) begin
      if (dor_q.motor[dor_q.drive]) begin
        selN_d = ~dor_q.drive;
      end
    end else begin
      selN_d[0] = ~(dor_q.drive == 2'd0 && dor_q.motor[0]);
      selN_d[1] = ~(dor_q.drive == 2'd1 && dor_q.motor[1]);
    end
  end

  // Pins come straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepDirection <= 1'b0;
      drive_select0_n <= 1'b1;
      drive_select1_n <= 1'b1;
      rate_code_out0 <= 1'b0;
      rate_code_out1 <= 1'b0;
      read_gate_diag <= 1'b0;
      floppy_dma_req <= 1'b0;
      dmaStrobeEnable <= 1'b0;
    end else begin
      stepDirection <= stepDir_d;
      drive_select0_n <= selN_d[0];
      drive_select1_n <= selN_d[1];
      rate_code_out0 <= rate_q[0];
      rate_code_out1 <= rate_q[1];
      read_gate_diag <= diagSel_q & diskSync;
      floppy_dma_req <= dmaEnable & (count_q != '0);
      dmaStrobeEnable <= ackActive;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    unique case ({haddr[fdc_pkg::ADDR_MSB:fdc_pkg::ADDR_LSB], 2'b00})
      fdc_pkg::OFS_DRIVE_CTL: rdMux[7:0] = dor_q;
      fdc_pkg::OFS_FUNC_EN: rdMux[7:0] = fer_q;
      fdc_pkg::OFS_RATE_CFG: rdMux[1:0] = rateCfg_q;
      fdc_pkg::OFS_RATE_SEL: rdMux[1:0] = rateSel_q;
      fdc_pkg::OFS_IN_STATUS: begin
        rdMux[fdc_pkg::STAT_DISK] = ~diagSel_q & diskSync;
        rdMux[fdc_pkg::STAT_DIAG] = diagSel_q & diskSync;
      end
      fdc_pkg::OFS_MODE: rdMux[3:0] = {diagSel_q, mode_q};
      fdc_pkg::OFS_SEEK: rdMux[2:0] = seek_q;
      fdc_pkg::OFS_XFER: begin
        rdMux[COUNT_W-1:0] = count_q;
        rdMux[fdc_pkg::XFER_REQ] = floppy_dma_req;
        rdMux[fdc_pkg::XFER_ACK] = ackActive;
        rdMux[fdc_pkg::XFER_SEEN] = ackSeen_q;
      end
      default: rdMux = '0;
    endcase
  end

  // Read data loaded at the address phase edge, stable in data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      rdata_q <= rdMux;
    end
  end

  // Checks of pin behaviour against register state
  sequence s_rate_cfg_wr;
    wrEn && wrOfs == fdc_pkg::OFS_RATE_CFG;
  endsequence

  sequence s_rate_sel_wr;
    wrEn && wrOfs == fdc_pkg::OFS_RATE_SEL;
  endsequence

  a_dir_inward: assert property (@(posedge clk) disable iff (rst)
    seek_q.seekActive && seek_q.inward && !seek_q.rwActive |=> stepDirection)
    else $error("step direction not inward during seek");

  a_dir_rw_idle: assert property (@(posedge clk) disable iff (rst)
    seek_q.rwActive |=> !stepDirection)
    else $error("step direction active during read or write");

  a_sel_decode: assert property (@(posedge clk) disable iff (rst)
    !fer_q[fdc_pkg::FER_FOUR_DRIVE] && dor_q.drive == 2'd1 && dor_q.motor[1]
    |=> !drive_select1_n && drive_select0_n)
    else $error("drive one not selected");

  a_sel_gate: assert property (@(posedge clk) disable iff (rst)
    !fer_q[fdc_pkg::FER_FOUR_DRIVE] && !dor_q.motor[dor_q.drive]
    |=> drive_select0_n && drive_select1_n)
    else $error("select active without motor enable");

  a_sel_low: assert property (@(posedge clk) disable iff (rst)
    !fer_q[fdc_pkg::FER_FOUR_DRIVE] && dor_q.drive == 2'd0 && dor_q.motor[0]
    |=> !drive_select0_n)
    else $error("drive zero select not low");

  a_sel_encode: assert property (@(posedge clk) disable iff (rst)
    fer_q[fdc_pkg::FER_FOUR_DRIVE] && dor_q.motor[dor_q.drive]
    |=> {drive_select1_n, drive_select0_n} == ~$past(dor_q.drive))
    else $error("encoded select wrong");

  a_rate_last_cfg: assert property (@(posedge clk) disable iff (rst)
    s_rate_cfg_wr ##1 !(wrEn && (wrOfs == fdc_pkg::OFS_RATE_CFG || wrOfs == fdc_pkg::OFS_RATE_SEL))
    |=> {rate_code_out1, rate_code_out0} == $past(rateCfg_q))
    else $error("rate pins miss config write");

  a_rate_last_sel: assert property (@(posedge clk) disable iff (rst)
    s_rate_sel_wr ##1 !(wrEn && (wrOfs == fdc_pkg::OFS_RATE_CFG || wrOfs == fdc_pkg::OFS_RATE_SEL))
    |=> {rate_code_out1, rate_code_out0} == $past(rateSel_q))
    else $error("rate pins miss select write");

  a_diag_route: assert property (@(posedge clk) disable iff (rst)
    !diagSel_q |=> !read_gate_diag)
    else $error("diagnostic gate active while not selected");

  a_req_need: assert property (@(posedge clk) disable iff (rst)
    dmaEnable && count_q != '0 |=> floppy_dma_req)
    else $error("request missing while data needed");

  a_ack_strobe: assert property (@(posedge clk) disable iff (rst)
    $fell(ackSync) && dmaEnable |=> dmaStrobeEnable)
    else $error("strobes not enabled on acknowledge");

  a_req_gated: assert property (@(posedge clk) disable iff (rst)
    mode_q != fdc_pkg::MODE_ALT && !dor_q.dmaGate |=> !floppy_dma_req && !dmaStrobeEnable)
    else $error("dma active with gate bit clear");

  a_alt_always: assert property (@(posedge clk) disable iff (rst)
    mode_q == fdc_pkg::MODE_ALT && count_q != '0 |=> floppy_dma_req)
    else $error("alternate mode request blocked");
endmodule

// ---- bench/fdc_dma_partner.sv ----
// Partner model: the system DMA controller answering the floppy request.
// Assumes one clock shared with the block; the ack pin idles high.
`timescale 1ns/1ps
module fdc_dma_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic floppy_dma_req,
  input wire logic autoOn,
  input wire logic pulseNow,
  input wire logic [3:0] gapCyc,
  output logic floppy_dma_ack_n
);
  // One low pulse per grant; pulseNow forces one even without a request
  initial begin
    floppy_dma_ack_n = 1'b1;
    forever begin
      @(posedge clk);
      if (!rst && (pulseNow || (autoOn && floppy_dma_req))) begin
        repeat (gapCyc) @(posedge clk); // Slow answer when gap is set
        floppy_dma_ack_n <= 1'b0;
        repeat (4) @(posedge clk);
        floppy_dma_ack_n <= 1'b1;
        repeat (3) @(posedge clk); // Lets the request fall before looking again
      end
    end
  end
endmodule

// ---- bench/test_floppy_drive_ctl_dma.sv ----
// Self-checking bench for the floppy drive pin and DMA control block.
// Assumes the block and its DMA partner share one 100 MHz clock.
`timescale 1ns/1ps
module test_floppy_drive_ctl_dma;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic dsk = 1'b0;
  logic autoOn = 1'b0;
  logic pulseNow = 1'b0;
  logic [3:0] gapCyc = 4'h0;
  logic [31:0] hrdata, rdv, v;
  logic hreadyout, hresp, ackN, step, sel0N, sel1N, rate0, rate1, rgDiag, req, strobe, en;
  int badCount = 0;
  int checkCount = 0;
  int seed = 32'h0000_dcc6;

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  fdc_drive_ctl #(.COUNT_W(8)) i_fdc_drive_ctl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .disk_changed_in(dsk),
    .floppy_dma_ack_n(ackN), .stepDirection(step), .drive_select0_n(sel0N),
    .drive_select1_n(sel1N), .rate_code_out0(rate0), .rate_code_out1(rate1),
    .read_gate_diag(rgDiag), .floppy_dma_req(req), .dmaStrobeEnable(strobe));

  fdc_dma_partner i_fdc_dma_partner (.clk(clk), .rst(rst), .floppy_dma_req(req), .autoOn(autoOn),
    .pulseNow(pulseNow), .gapCyc(gapCyc), .floppy_dma_ack_n(ackN));

  task automatic printVerdict;
    $display("Counts: %0d compares, %0d mismatches", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare and count; case inequality so unknowns never match
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait: 0 bus ready, 1 ack pin, 2 request pin
  task automatic waitFor(input int which, input logic lvl, input int lim);
    logic s;
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      s = (which == 0) ? hreadyout : (which == 1) ? ackN : req;
      if (s === lvl) return;
    end
    badCount++;
    $display("wait timed out at %0t", $time);
    printVerdict();
  endtask

  // One single AHB-Lite word transfer; read data lands in rdv
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    waitFor(0, 1'b1, 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitFor(0, 1'b1, 50);
    rdv = hrdata;
  endtask

  // Pins follow a register one edge after the write completes
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // Expected {select1, select0}, active low
  function automatic logic [1:0] selExp(input logic [7:0] drive_output_ctl_reg, input logic four);
    if (four) begin
      return drive_output_ctl_reg[4 + drive_output_ctl_reg[1:0]] ? ~drive_output_ctl_reg[1:0] : 2'h3;
    end
    return {~(drive_output_ctl_reg[1:0] == 2'h1 && drive_output_ctl_reg[5]), ~(drive_output_ctl_reg[1:0] == 2'h0 && drive_output_ctl_reg[4])};
  endfunction

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({24'h00_0000, step, sel1N, sel0N, rate1, rate0, req, strobe, rgDiag}, 32'h0000_0060);
    check({30'h0, hreadyout, hresp}, 32'h0000_0002);
    busXfer(1'b0, fdc_pkg::OFS_MODE, 32'h0000_0000);
    check(rdv, 32'h0000_0001);
    busXfer(1'b0, 8'h20, 32'h0000_0000);
    check(rdv, 32'h0000_0000);
    $display("reset test done");
    // Random drive numbers and motor bits, decoded and four-drive forms
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      busXfer(1'b1, fdc_pkg::OFS_FUNC_EN, {27'h000_0000, i[0], 4'h0});
      busXfer(1'b1, fdc_pkg::OFS_DRIVE_CTL, {24'h00_0000, v[7:0]});
      settle();
      check({30'h0, sel1N, sel0N}, {30'h0, selExp(v[7:0], i[0])});
    end
    $display("select test done");
    for (int s = 0; s < 8; s++) begin
      busXfer(1'b1, fdc_pkg::OFS_SEEK, s);
      settle();
      check({31'h0, step}, {31'h0, s[0] & s[1] & ~s[2]});
    end
    $display("step test done");
    // Either rate register, last write wins
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      busXfer(1'b1, v[2] ? fdc_pkg::OFS_RATE_SEL : fdc_pkg::OFS_RATE_CFG, {30'h0, v[1:0]});
      settle();
      check({30'h0, rate1, rate0}, {30'h0, v[1:0]});
    end
    $display("rate test done");
    for (int i = 0; i < 4; i++) begin
      dsk <= i[0];
      busXfer(1'b1, fdc_pkg::OFS_MODE, {28'h000_0000, i[1], 3'h1});
      repeat (4) @(posedge clk);
      busXfer(1'b0, fdc_pkg::OFS_IN_STATUS, 32'h0000_0000);
      check(rdv & 32'h0000_0080, {24'h00_0000, i[0] & ~i[1], 7'h0});
      check(rdv & 32'h0000_0001, {31'h0, i[0] & i[1]});
      check({31'h0, rgDiag}, {31'h0, i[0] & i[1]});
    end
    $display("disk change test done");
    // Every mode with the gate bit clear and set; partner acks regardless
    for (int m = 0; m < 6; m++) begin
      en = m[0] | (m >= 4);
      busXfer(1'b1, fdc_pkg::OFS_MODE, {29'h0, 3'h1 << (m / 2)});
      busXfer(1'b1, fdc_pkg::OFS_DRIVE_CTL, {28'h000_0000, m[0], 3'h0});
      busXfer(1'b1, fdc_pkg::OFS_XFER, 32'h0000_0001);
      settle();
      check({31'h0, req}, {31'h0, en});
      v = $random(seed);
      gapCyc <= {1'b0, v[2:0]};
      pulseNow <= 1'b1;
      @(posedge clk);
      pulseNow <= 1'b0;
      waitFor(1, 1'b0, 20);
      repeat (3) @(posedge clk);
      check({31'h0, strobe}, {31'h0, en});
      repeat (6) @(posedge clk);
      check({31'h0, req}, 32'h0000_0000);
      busXfer(1'b0, fdc_pkg::OFS_XFER, 32'h0000_0000);
      check(rdv & 32'h0000_00ff, {31'h0, ~en});
    end
    // Three transfers answered slowly in alternate mode, ack flag cleared first
    busXfer(1'b1, fdc_pkg::OFS_XFER, 32'h0000_0403);
    gapCyc <= 4'h5;
    autoOn <= 1'b1;
    waitFor(2, 1'b1, 10);
    waitFor(2, 1'b0, 200);
    autoOn <= 1'b0;
    repeat (8) @(posedge clk);
    busXfer(1'b0, fdc_pkg::OFS_XFER, 32'h0000_0000);
    check(rdv & 32'h0000_04ff, 32'h0000_0400);
    $display("dma test done");
    // Reset in mid-run puts every pin back to idle, rate code included
    busXfer(1'b1, fdc_pkg::OFS_RATE_CFG, 32'h0000_0003);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({24'h00_0000, step, sel1N, sel0N, rate1, rate0, req, strobe, rgDiag}, 32'h0000_0060);
    $display("mid-run reset test done");
    printVerdict();
  end
endmodule
